// File: core/wake_pkg.sv
// constants for the wakeup flag and reset entry block
// Functional notes
// - Bits 7 and 6 of the wakeup flag register are unused and always read as one.
// - A wakeup flag sets when its pin is an interrupt input and the selected edge is seen.
// - Software clears a wakeup flag by writing zero to it; flags are zero after reset.
// - A low reset pin stops all processing and puts the device in reset.
// - In reset, processor state and all peripheral registers return to initial values.
// - When the reset pin rises after a long enough low, the reset sequence begins.
// - The first step of the reset sequence sets the interrupt mask bit to one.
// - Then the reset vector word is read from the two lowest bytes into the program counter.
// - All six wakeup interrupts share one vector and one enable bit.
// - After reset every interrupt, the non-maskable one too, is refused until one instruction ran; the irq event line is not gated by the retire bit.
package wake_pkg;
    localparam logic [11:0] FLAGS_OFFSET    = 12'h000;
    localparam logic [11:0] MODE_OFFSET     = 12'h004;
    localparam logic [11:0] EDGE_OFFSET     = 12'h008;
    localparam logic [11:0] CTRL_OFFSET     = 12'h00C;
    localparam logic [11:0] PC_OFFSET       = 12'h010;
    localparam logic [11:0] STAT_OFFSET     = 12'h014;
    localparam logic [11:0] INT_STAT_OFFSET = 12'h018;
    localparam logic [11:0] INT_MASK_OFFSET = 12'h01C;
    localparam int          NUM_WAKE        = 6;
    localparam logic [1:0]  FLAGS_UNUSED    = 2'h3;
    localparam logic [15:0] VECTOR_ADDR     = 16'h0000;
    localparam int          CTRL_IEN_BIT    = 0;
    localparam int          CTRL_RETIRE_BIT = 1;
    localparam int          CTRL_NMI_BIT    = 2;
    localparam int          MIN_RESET_CYC   = 10;
    localparam logic [3:0]  RST_CNT_MAX     = 4'hF;
    localparam int          EV_WAKE         = 0;
    localparam int          EV_VECTOR       = 1;
    localparam int          EV_SHORT_RESET  = 2;
    typedef enum logic [1:0] {ST_RESET, ST_SET_MASK, ST_FETCH, ST_RUN} entry_state_t;
endpackage

// File: core/wake_reset_unit.sv
// wakeup flag register and reset entry sequencer with apb access
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module wake_reset_unit #(
    parameter int NUM_WAKE = 6
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                reset_n,

    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,

    // wakeup pins
    input  wire logic [NUM_WAKE-1:0] wake_pin,

    // reset vector word from memory
    output logic                     vec_rd,
    output logic [15:0]              vec_addr,
    input  wire logic [15:0]         vec_data,

    // processor side
    output logic                     cpu_hold,
    output logic                     mask_bit,
    output logic [15:0]              pc_out,
    output logic                     wake_irq_req,
    output logic                     nmi_req,
    output logic                     irq
);

    // register map, byte offsets
    // 0x00 wake flags: upper two bits read one, write 0 clears, 1 keeps
    // 0x04 interrupt-input select per pin
    // 0x08 edge select per pin, one for rising
    // 0x0C control: wake enable, first retire, nmi pending
    // 0x10 start address taken from the vector
    // 0x14 status: mask, short flag, hold, live bit for low count below minimum
    // 0x18 event status, write one clears
    // 0x1C event mask, a one masks that event
    // event bits: 0 wake edge, 1 vector fetch, 2 short reset
    // irq is a level while an unmasked event bit is set
    // unmapped reads return zero, unmapped writes are ignored

    logic [1:0]          rst_sync_reg;
    logic                rst_n;

    logic [NUM_WAKE-1:0] pin_s1_reg;
    logic [NUM_WAKE-1:0] pin_s2_reg;
    logic [NUM_WAKE-1:0] pin_prev_reg;

    logic [NUM_WAKE-1:0] flags_reg;
    logic [NUM_WAKE-1:0] mode_reg;
    logic [NUM_WAKE-1:0] edge_reg;
    logic                ien_reg;
    logic                nmi_pend_reg;
    logic                retired_reg;
    logic                mask_reg;
    logic [15:0]         pc_reg;
    logic                vec_rd_reg;

    logic [3:0]          low_cnt_reg = 4'h0;
    logic                short_reg;
    logic [2:0]          int_stat_reg;
    logic [2:0]          int_mask_reg;
    logic [31:0]         prdata_reg;

    logic [NUM_WAKE-1:0] edge_hit;
    logic                fetching;
    logic                short_pulse;
    logic                wr;
    logic                rd;
    logic [2:0]          events;
    wake_pkg::entry_state_t st_reg;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // apb decode; the slave never inserts wait states
    assign wr      = psel && penable && pwrite;
    assign rd      = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_reg;

    // pin reset released through two stages; async assert halts everything but the low-time counter
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // short-reset flag taken once per entry, at the vector fetch
    // power-up low time is measured too, so a brief power-up reset is flagged
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            short_reg <= 1'b0;
        else if (fetching)
            short_reg <= short_pulse;
    end

    // counts cycles spent in reset to flag a too-short pulse
    // saturates so a long hold cannot wrap back to short
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            if (low_cnt_reg != wake_pkg::RST_CNT_MAX)
                low_cnt_reg <= low_cnt_reg + 4'h1;
        end
        else if (st_reg == wake_pkg::ST_RUN)
            low_cnt_reg <= 4'h0;
    end

    // two flops against metastability; the prev stage gives the edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_reg   <= '0;
            pin_s2_reg   <= '0;
            pin_prev_reg <= '0;
        end
        else
        begin
            pin_s1_reg   <= wake_pin;
            pin_s2_reg   <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // edge_reg bit one selects rising, zero falling
    assign edge_hit = mode_reg & ((edge_reg & pin_s2_reg & ~pin_prev_reg)
                    | (~edge_reg & ~pin_s2_reg & pin_prev_reg));

    // set wins over a same-cycle clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_reg <= '0;
        else if (wr && hit(paddr, wake_pkg::FLAGS_OFFSET))
            flags_reg <= (flags_reg & pwdata[NUM_WAKE-1:0]) | edge_hit;
        else
            flags_reg <= flags_reg | edge_hit;
    end

    // pin mode, edge select and wake enable
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg <= '0;
            edge_reg <= '0;
            ien_reg  <= 1'b0;
        end
        else if (wr)
        begin
            if (hit(paddr, wake_pkg::MODE_OFFSET))
                mode_reg <= pwdata[NUM_WAKE-1:0];
            if (hit(paddr, wake_pkg::EDGE_OFFSET))
                edge_reg <= pwdata[NUM_WAKE-1:0];
            if (hit(paddr, wake_pkg::CTRL_OFFSET))
                ien_reg <= pwdata[wake_pkg::CTRL_IEN_BIT];
        end
    end

    // entry sequencer: set mask, fetch vector, run
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg      <= wake_pkg::ST_RESET;
            mask_reg    <= 1'b1;
            pc_reg      <= 16'h0000;
            vec_rd_reg  <= 1'b0;
            retired_reg <= 1'b0;
        end
        else
        begin
            vec_rd_reg <= 1'b0;
            case (st_reg)
                wake_pkg::ST_RESET:
                begin
                    st_reg <= wake_pkg::ST_SET_MASK;
                end
                wake_pkg::ST_SET_MASK:
                begin
                    mask_reg   <= 1'b1;
                    vec_rd_reg <= 1'b1;
                    st_reg     <= wake_pkg::ST_FETCH;
                end
                wake_pkg::ST_FETCH:
                begin
                    // the word is sampled in the same cycle as the read pulse
                    pc_reg <= vec_data;
                    st_reg <= wake_pkg::ST_RUN;
                end
                wake_pkg::ST_RUN:
                begin
                    if (wr && hit(paddr, wake_pkg::CTRL_OFFSET)
                        && pwdata[wake_pkg::CTRL_RETIRE_BIT])
                        retired_reg <= 1'b1;
                    // mask is software-writable only once running
                    if (wr && hit(paddr, wake_pkg::STAT_OFFSET))
                        mask_reg <= pwdata[0];
                end
                default:
                begin
                    st_reg <= wake_pkg::ST_RESET;
                end
            endcase
        end
    end

    // nmi pending is held off by the retire gate below
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            nmi_pend_reg <= 1'b0;
        else if (wr && hit(paddr, wake_pkg::CTRL_OFFSET))
            nmi_pend_reg <= pwdata[wake_pkg::CTRL_NMI_BIT];
    end

    assign cpu_hold     = (st_reg != wake_pkg::ST_RUN);
    assign mask_bit     = mask_reg;
    assign pc_out       = pc_reg;
    assign vec_rd       = vec_rd_reg;
    assign vec_addr     = wake_pkg::VECTOR_ADDR;
    // one shared request gated by one enable and held off until first retire
    assign wake_irq_req = retired_reg && !mask_reg && ien_reg && (|flags_reg);
    assign nmi_req      = retired_reg && nmi_pend_reg;

    assign fetching    = (st_reg == wake_pkg::ST_FETCH);
    assign short_pulse = fetching && (low_cnt_reg < 4'(wake_pkg::MIN_RESET_CYC));

    assign events = {short_pulse, fetching, |edge_hit};

    // event status and mask; set wins over a same-cycle clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_stat_reg <= 3'h0;
            int_mask_reg <= 3'h0;
        end
        else
        begin
            if (wr && hit(paddr, wake_pkg::INT_STAT_OFFSET))
                int_stat_reg <= (int_stat_reg & ~pwdata[2:0]) | events;
            else
                int_stat_reg <= int_stat_reg | events;

            if (wr && hit(paddr, wake_pkg::INT_MASK_OFFSET))
                int_mask_reg <= pwdata[2:0];
        end
    end
    // a set mask bit hides its event from the line
    assign irq = |(int_stat_reg & ~int_mask_reg);

    // read data registered in the setup cycle, stands through access
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata_reg <= 32'h0000_0000;
        else if (rd)
        begin
            case (paddr)
                wake_pkg::FLAGS_OFFSET:
                    prdata_reg <= {24'h0, wake_pkg::FLAGS_UNUSED, flags_reg};
                wake_pkg::MODE_OFFSET:
                    prdata_reg <= {26'h0, mode_reg};
                wake_pkg::EDGE_OFFSET:
                    prdata_reg <= {26'h0, edge_reg};
                wake_pkg::CTRL_OFFSET:
                    prdata_reg <= {29'h0, nmi_pend_reg, retired_reg, ien_reg};
                wake_pkg::PC_OFFSET:
                    prdata_reg <= {16'h0, pc_reg};
                wake_pkg::STAT_OFFSET:
                    prdata_reg <= {28'h0, low_cnt_reg < 4'(wake_pkg::MIN_RESET_CYC), cpu_hold,
                                   short_reg, mask_reg};
                wake_pkg::INT_STAT_OFFSET:
                    prdata_reg <= {29'h0, int_stat_reg};
                wake_pkg::INT_MASK_OFFSET:
                    prdata_reg <= {29'h0, int_mask_reg};
                default:
                    prdata_reg <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// File: bench/wake_src_model.sv
// wakeup pin sources and reset vector memory seen from outside the unit
`timescale 1ns/1ps
module wake_src_model #(
    parameter logic [15:0] VEC_WORD = 16'h0100
) (
    // clock and vector read
    input  wire logic        sys_clk,
    input  wire logic        vec_rd,
    input  wire logic [15:0] vec_addr,
    output logic      [15:0] vec_data,
    // pins as commanded by the bench
    input  wire logic [5:0]  pin_cmd,
    output logic      [5:0]  wake_pin
);
    logic rd_q = 1'b0;
    always @(posedge sys_clk)
        rd_q <= vec_rd;
    // word held through the read and one cycle after, inverted otherwise, so a sample two or more cycles late shows up
    assign vec_data = ((vec_rd || rd_q) && vec_addr == wake_pkg::VECTOR_ADDR) ? VEC_WORD
                                                                             : ~VEC_WORD;
    assign wake_pin = pin_cmd;
endmodule

// File: bench/wake_reset_checker.sv
// concurrent checks on the wakeup flag and reset entry unit ports
`timescale 1ns/1ps
module wake_reset_checker (
    // clock, reset and apb
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // reset entry and requests
    input wire logic        vec_rd,
    input wire logic [15:0] vec_addr,
    input wire logic        cpu_hold,
    input wire logic        mask_bit,
    input wire logic [15:0] pc_out,
    input wire logic        wake_irq_req,
    input wire logic        nmi_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_top_ones; psel && !penable && !pwrite && paddr == wake_pkg::FLAGS_OFFSET
        |=> prdata[7:6] == wake_pkg::FLAGS_UNUSED; endproperty
    a_top_ones: assert property (p_top_ones) else $error("upper flag bits not one");
    property p_rst_init; $rose(reset_n) |-> cpu_hold && mask_bit && pc_out == 16'h0000
        && !vec_rd && !nmi_req; endproperty
    a_rst_init: assert property (p_rst_init) else $error("state not initial");
    property p_seq; $rose(reset_n) |-> cpu_hold [*3] ##[1:4] vec_rd; endproperty
    a_seq: assert property (p_seq) else $error("entry sequence missing");
    property p_mask_first; vec_rd |-> mask_bit && cpu_hold; endproperty
    a_mask_first: assert property (p_mask_first) else $error("mask not set first");
    property p_vec_addr; vec_rd |-> vec_addr == wake_pkg::VECTOR_ADDR; endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("wrong vector address");
    property p_vec_once; vec_rd |=> !vec_rd; endproperty
    a_vec_once: assert property (p_vec_once) else $error("vector read repeated");
    property p_start; vec_rd |-> ##[1:2] !cpu_hold; endproperty
    a_start: assert property (p_start) else $error("no start after fetch");
    property p_no_early; $fell(cpu_hold) |-> !wake_irq_req && !nmi_req; endproperty
    a_no_early: assert property (p_no_early) else $error("request right after reset");
    property p_wake_mask; wake_irq_req |-> !mask_bit && !cpu_hold; endproperty
    a_wake_mask: assert property (p_wake_mask) else $error("wake request while masked");
endmodule
bind wake_reset_unit wake_reset_checker u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .vec_rd(vec_rd), .vec_addr(vec_addr), .cpu_hold(cpu_hold), .mask_bit(mask_bit),
    .pc_out(pc_out), .wake_irq_req(wake_irq_req), .nmi_req(nmi_req));

// File: bench/wake_reset_unit_tb_top.sv
// self-checking bench for the wakeup flag and reset entry unit
`timescale 1ns/1ps
module wake_reset_unit_tb_top;
    localparam logic [15:0] START = 16'h0100;
    logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, vec_rd, cpu_hold, mask_bit, wake_irq_req, nmi_req, irq;
    logic [5:0]  pin_cmd = 6'h15, wake_pin;
    logic [15:0] vec_addr, vec_data, pc_out;
    logic [15:0] rows [4] = '{16'h3FFF, 16'h3EFE, 16'h15D4, 16'h00C0};
    int          err_count = 0, comparisons = 0;
    always #25 sys_clk = ~sys_clk;
    wake_reset_unit #(.NUM_WAKE(wake_pkg::NUM_WAKE)) u_dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .wake_pin(wake_pin), .vec_rd(vec_rd), .vec_addr(vec_addr), .vec_data(vec_data),
        .cpu_hold(cpu_hold), .mask_bit(mask_bit), .pc_out(pc_out),
        .wake_irq_req(wake_irq_req), .nmi_req(nmi_req), .irq(irq));
    wake_src_model #(.VEC_WORD(START)) u_src (.sys_clk(sys_clk), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .vec_data(vec_data), .pin_cmd(pin_cmd), .wake_pin(wake_pin));
    task automatic test_done;
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pins(input logic [5:0] v);
        @(posedge sys_clk);
        pin_cmd <= v;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic wait_run;
        int n;
        n = 0;
        while (cpu_hold !== 1'b0 && n < 100)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("cpu_hold", 32'h0, {31'h0, cpu_hold});
    endtask
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_run;
        chk("pc_out", {16'h0, START}, {16'h0, pc_out});
        chk("mask_bit", 32'h1, {31'h0, mask_bit});
        rdchk("flags", wake_pkg::FLAGS_OFFSET, 32'hC0);
        rdchk("unmapped", 12'h040, 32'h0);
        apb(1'b1, wake_pkg::MODE_OFFSET, 32'h3F);
        apb(1'b1, wake_pkg::EDGE_OFFSET, 32'h2A);
        pins(6'h2A);
        rdchk("flags", wake_pkg::FLAGS_OFFSET, 32'hFF);
        foreach (rows[i])
        begin
            apb(1'b1, wake_pkg::FLAGS_OFFSET, {24'h0, rows[i][15:8]});
            rdchk("flags", wake_pkg::FLAGS_OFFSET, {24'h0, rows[i][7:0]});
        end
        apb(1'b1, wake_pkg::MODE_OFFSET, 32'h3E);
        pins(6'h15);
        rdchk("flags", wake_pkg::FLAGS_OFFSET, 32'hC0);
        pins(6'h2A);
        rdchk("flags", wake_pkg::FLAGS_OFFSET, 32'hFE);
        rdchk("irq_stat", wake_pkg::INT_STAT_OFFSET, 32'h7);
        chk("irq_stat", 32'h3, rd & 32'h3);
        apb(1'b1, wake_pkg::INT_MASK_OFFSET, 32'h7);
        rdchk("irq_mask", wake_pkg::INT_MASK_OFFSET, 32'h7);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, wake_pkg::INT_MASK_OFFSET, 32'h0);
        rdchk("irq_mask", wake_pkg::INT_MASK_OFFSET, 32'h0);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, wake_pkg::INT_STAT_OFFSET, 32'h7);
        rdchk("irq_stat", wake_pkg::INT_STAT_OFFSET, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, wake_pkg::STAT_OFFSET, 32'h0);
        apb(1'b1, wake_pkg::CTRL_OFFSET, 32'h5);
        @(negedge sys_clk);
        chk("wake_req", 32'h0, {31'h0, wake_irq_req});
        chk("nmi_req", 32'h0, {31'h0, nmi_req});
        apb(1'b1, wake_pkg::CTRL_OFFSET, 32'h7);
        @(negedge sys_clk);
        chk("wake_req", 32'h1, {31'h0, wake_irq_req});
        chk("nmi_req", 32'h1, {31'h0, nmi_req});
        apb(1'b1, wake_pkg::STAT_OFFSET, 32'h1);
        @(negedge sys_clk);
        chk("wake_req", 32'h0, {31'h0, wake_irq_req});
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        chk("hold", 32'h1, {31'h0, cpu_hold});
        chk("pc_out", 32'h0, {16'h0, pc_out});
        reset_n <= 1'b1;
        wait_run;
        chk("wake_req", 32'h0, {31'h0, wake_irq_req});
        rdchk("flags", wake_pkg::FLAGS_OFFSET, 32'hC0);
        rdchk("pc", wake_pkg::PC_OFFSET, {16'h0, START});
        rdchk("irq_stat", wake_pkg::INT_STAT_OFFSET, 32'h2);
        test_done;
    end
    initial
    begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        test_done;
    end
endmodule
